// ---- pin_status_mux.sv ----
// multifunction status pin selector for the four digital loops
//
// The plain strobed port and the address map were chosen for this implementation.
`include "pin_mux_params.svh"
`default_nettype none

module pin_status_mux #(
	parameter int LOOPS = 4,
	parameter int REFS = 4
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// status flags from the loops, same clock
	input wire pin_mux_pkg::loop_flags_t [LOOPS-1:0] flags_in,
	// per reference, which loop uses it as active input
	input wire logic [REFS-1:0][LOOPS-1:0] ref_active_in,
	// multifunction pin
	output logic pin_out,
	output logic pin_oe_out
);

	// one flag out of a loop's set, chosen by the low nibble
	function automatic logic pick_flag(
		input logic [3:0] nib,
		input pin_mux_pkg::loop_flags_t f,
		input logic act
	);
		logic r;
		r = 1'b0;
		case (pin_mux_pkg::flag_sel_e'(nib))
			pin_mux_pkg::SEL_PHASE: r = f.phase_lock;
			pin_mux_pkg::SEL_FREQ: r = f.freq_lock;
			pin_mux_pkg::SEL_ANALOG: r = f.analog_lock;
			pin_mux_pkg::SEL_CAL: r = f.analog_cal;
			pin_mux_pkg::SEL_ACTIVE: r = act;
			pin_mux_pkg::SEL_FREE: r = f.free_run;
			pin_mux_pkg::SEL_HOLD: r = f.holdover;
			pin_mux_pkg::SEL_SWITCH: r = f.switching;
			pin_mux_pkg::SEL_HAVAIL: r = f.hist_avail;
			pin_mux_pkg::SEL_HUPD: r = f.hist_upd;
			pin_mux_pkg::SEL_CLAMP: r = f.clamp;
			pin_mux_pkg::SEL_SLEW: r = f.slew_limited;
			pin_mux_pkg::SEL_SYNC: r = f.sync_pulse;
			pin_mux_pkg::SEL_DEMAP: r = f.demap_clamped;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : pick_flag

	// true when the code lies in the loop status range served here
	function automatic logic code_served(input logic [7:0] code);
		logic r;
		r = (code[7:6] == `LOOP_GRP);
		if (code[`LOOP_HI:`LOOP_LO] == 2'b00 && code[3:0] < `LOOP0_FIRST)
		begin
			r = 1'b0;
		end
		return r;
	endfunction : code_served

	pin_mux_pkg::mux_state_t s;
	pin_mux_pkg::mux_state_t next_s;
	logic [LOOPS-1:0] loop_act;
	logic [LOOPS-1:0] loop_bit;
	logic [1:0] loop_idx;

	// per loop: active is the OR over references, then pick the flag
	for (genvar l = 0; l < LOOPS; l++)
	begin : g_loop
		logic [REFS-1:0] col;
		for (genvar r = 0; r < REFS; r++)
		begin : g_ref
			assign col[r] = ref_active_in[r][l];
		end
		assign loop_act[l] = |col;
		assign loop_bit[l] = pick_flag(s.func_code[3:0], flags_in[l], loop_act[l]);
	end

	assign loop_idx = s.func_code[`LOOP_HI:`LOOP_LO];

	// next state: register port and pin selection
	always_comb
	begin
		next_s = s;
		if (wr_in && addr_in == `FUNC_OFS)
		begin
			next_s.func_code = wdata_in;
		end
		next_s.rdata = 8'h00;
		if (rd_in)
		begin
			case (addr_in)
				`FUNC_OFS: next_s.rdata = s.func_code;
				`STAT_OFS:
				begin
					next_s.rdata[`STAT_PIN] = s.pin;
					next_s.rdata[`STAT_OE] = s.pin_oe;
				end
				default: next_s.rdata = 8'h00;
			endcase
		end
		// top bit set turns the pin into an output
		next_s.pin_oe = s.func_code[`DIR_BIT];
		// served codes with a listed nibble route a flag, all others hold low
		if (code_served(s.func_code))
		begin
			next_s.pin = loop_bit[loop_idx];
		end
		else
		begin
			next_s.pin = 1'b0;
		end
	end

	// state register, pin leaves straight from a flip-flop
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s.func_code <= `FUNC_RST;
			s.pin <= 1'b0;
			s.pin_oe <= 1'b0;
			s.rdata <= 8'h00;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign pin_out = s.pin;
	assign pin_oe_out = s.pin_oe;
	assign rdata_out = s.rdata;

	// checks on the selector
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// direction follows the top bit one cycle later
	a_dir_follow: assert property (
		s.func_code[`DIR_BIT] |=> pin_oe_out
	) else $error("pin not driven for output code");

	// input codes never drive the pin
	a_dir_input: assert property (
		!s.func_code[`DIR_BIT] |=> !pin_oe_out && !pin_out
	) else $error("pin driven for input code");

	// loop 0 clamp
	a_loop0_clamp: assert property (
		s.func_code == 8'hca |=> pin_out == $past(flags_in[0].clamp)
	) else $error("loop 0 clamp not on pin");

	// loop 0 slew limit
	a_loop0_slew: assert property (
		s.func_code == 8'hcb |=> pin_out == $past(flags_in[0].slew_limited)
	) else $error("loop 0 slew flag not on pin");

	// sync pulse of loop 2 passes with one cycle delay
	a_sync_pulse: assert property (
		s.func_code == 8'hec && flags_in[2].sync_pulse
		|=> pin_out
	) else $error("loop 2 sync pulse lost");

	// loop 0 demapping clamp
	a_loop0_demap: assert property (
		s.func_code == 8'hcd |=> pin_out == $past(flags_in[0].demap_clamped)
	) else $error("loop 0 demap clamp not on pin");

	// loop 1 calibration busy
	a_loop1_cal: assert property (
		s.func_code == 8'hd3 |=> pin_out == $past(flags_in[1].analog_cal)
	) else $error("loop 1 calibration flag not on pin");

	// loop 1 active is the OR of the references
	a_loop1_active: assert property (
		s.func_code == 8'hd4
		|=> pin_out == $past(ref_active_in[0][1] | ref_active_in[1][1]
			| ref_active_in[2][1] | ref_active_in[3][1])
	) else $error("loop 1 active wrong");

	// loop 1 holdover
	a_loop1_hold: assert property (
		s.func_code == 8'hd6 |=> pin_out == $past(flags_in[1].holdover)
	) else $error("loop 1 holdover not on pin");

	// loop 1 history available
	a_loop1_hist: assert property (
		s.func_code == 8'hd8 |=> pin_out == $past(flags_in[1].hist_avail)
	) else $error("loop 1 history flag not on pin");

	// loop 1 history event shows for exactly one cycle, the cycle after its own
	a_loop1_event: assert property (
		s.func_code == 8'hd9 && flags_in[1].hist_upd
		##1 s.func_code == 8'hd9 && !flags_in[1].hist_upd
		|-> pin_out ##1 !pin_out
	) else $error("loop 1 history event shape wrong");

	// loop 2 frequency lock
	a_loop2_freq: assert property (
		s.func_code == 8'he1 |=> pin_out == $past(flags_in[2].freq_lock)
	) else $error("loop 2 frequency lock not on pin");

	// loop 2 active
	a_loop2_active: assert property (
		s.func_code == 8'he4
		|=> pin_out == $past(ref_active_in[0][2] | ref_active_in[1][2]
			| ref_active_in[2][2] | ref_active_in[3][2])
	) else $error("loop 2 active wrong");

	// loop 2 switching
	a_loop2_switch: assert property (
		s.func_code == 8'he7 |=> pin_out == $past(flags_in[2].switching)
	) else $error("loop 2 switching not on pin");

	// loop 2 demapping clamp
	a_loop2_demap: assert property (
		s.func_code == 8'hed |=> pin_out == $past(flags_in[2].demap_clamped)
	) else $error("loop 2 demap clamp not on pin");

	// loop 2 history event
	a_loop2_event: assert property (
		s.func_code == 8'he9 |=> pin_out == $past(flags_in[2].hist_upd)
	) else $error("loop 2 history event not on pin");

	// loop 3 phase lock
	a_loop3_phase: assert property (
		s.func_code == 8'hf0 |=> pin_out == $past(flags_in[3].phase_lock)
	) else $error("loop 3 phase lock not on pin");

	// loop 3 active
	a_loop3_active: assert property (
		s.func_code == 8'hf4
		|=> pin_out == $past(ref_active_in[0][3] | ref_active_in[1][3]
			| ref_active_in[2][3] | ref_active_in[3][3])
	) else $error("loop 3 active wrong");

	// loop 3 free run
	a_loop3_free: assert property (
		s.func_code == 8'hf5 |=> pin_out == $past(flags_in[3].free_run)
	) else $error("loop 3 free run not on pin");

	// loop 3 phase slew
	a_loop3_slew: assert property (
		s.func_code == 8'hfb |=> pin_out == $past(flags_in[3].slew_limited)
	) else $error("loop 3 slew flag not on pin");

	// loop 3 history event
	a_loop3_event: assert property (
		s.func_code == 8'hf9 |=> pin_out == $past(flags_in[3].hist_upd)
	) else $error("loop 3 history event not on pin");

	// loop 0 distribution sync pulse
	a_loop0_sync: assert property (
		s.func_code == 8'hcc |=> pin_out == $past(flags_in[0].sync_pulse)
	) else $error("loop 0 sync pulse not on pin");

	// loop 1 phase lock
	a_loop1_phase: assert property (
		s.func_code == 8'hd0 |=> pin_out == $past(flags_in[1].phase_lock)
	) else $error("loop 1 phase lock not on pin");

	// loop 1 frequency lock
	a_loop1_freq: assert property (
		s.func_code == 8'hd1 |=> pin_out == $past(flags_in[1].freq_lock)
	) else $error("loop 1 frequency lock not on pin");

	// loop 1 free run
	a_loop1_free: assert property (
		s.func_code == 8'hd5 |=> pin_out == $past(flags_in[1].free_run)
	) else $error("loop 1 free run not on pin");

	// loop 1 switchover
	a_loop1_switch: assert property (
		s.func_code == 8'hd7 |=> pin_out == $past(flags_in[1].switching)
	) else $error("loop 1 switchover not on pin");

	// loop 1 clamp
	a_loop1_clamp: assert property (
		s.func_code == 8'hda |=> pin_out == $past(flags_in[1].clamp)
	) else $error("loop 1 clamp not on pin");

	// loop 1 demapping clamp
	a_loop1_demap: assert property (
		s.func_code == 8'hdd |=> pin_out == $past(flags_in[1].demap_clamped)
	) else $error("loop 1 demap clamp not on pin");

	// loop 2 phase lock
	a_loop2_phase: assert property (
		s.func_code == 8'he0 |=> pin_out == $past(flags_in[2].phase_lock)
	) else $error("loop 2 phase lock not on pin");

	// loop 2 history available
	a_loop2_hist: assert property (
		s.func_code == 8'he8 |=> pin_out == $past(flags_in[2].hist_avail)
	) else $error("loop 2 history flag not on pin");

	// loop 2 clamp
	a_loop2_clamp: assert property (
		s.func_code == 8'hea |=> pin_out == $past(flags_in[2].clamp)
	) else $error("loop 2 clamp not on pin");

	// loop 3 analog lock
	a_loop3_analog: assert property (
		s.func_code == 8'hf2 |=> pin_out == $past(flags_in[3].analog_lock)
	) else $error("loop 3 analog lock not on pin");

	// loop 3 holdover
	a_loop3_hold: assert property (
		s.func_code == 8'hf6 |=> pin_out == $past(flags_in[3].holdover)
	) else $error("loop 3 holdover not on pin");

	// loop 3 demapping clamp
	a_loop3_demap: assert property (
		s.func_code == 8'hfd |=> pin_out == $past(flags_in[3].demap_clamped)
	) else $error("loop 3 demap clamp not on pin");

	// reserved and unlisted codes stay low
	a_reserved_low: assert property (
		s.func_code inside {8'hfe, 8'hff, 8'hce, 8'hc9, 8'h80, 8'hbf}
		|=> !pin_out
	) else $error("reserved code drives pin high");

	// a written code reaches the pin two edges later
	a_code_latency: assert property (
		wr_in && addr_in == `FUNC_OFS && wdata_in == 8'hfe
		##1 !(wr_in && addr_in == `FUNC_OFS)
		|=> !pin_out && pin_oe_out
	) else $error("code change latency wrong");

	// read data stand only in the cycle after the strobe
	a_read_func: assert property (
		rd_in && addr_in == `FUNC_OFS |=> rdata_out == $past(s.func_code)
	) else $error("code read back wrong");

	a_read_idle: assert property (
		!rd_in |=> rdata_out == 8'h00
	) else $error("read data without strobe");

	// main scenarios
	c_sync_seen: cover property (
		s.func_code == 8'hfc ##1 pin_out
	);
	c_event_seen: cover property (
		s.func_code == 8'hd9 && flags_in[1].hist_upd ##1 pin_out
	);
	c_reserved: cover property (
		s.func_code == 8'hff ##1 pin_oe_out && !pin_out
	);
	c_write_read: cover property (
		wr_in && addr_in == `FUNC_OFS ##1 rd_in && addr_in == `FUNC_OFS
	);

endmodule : pin_status_mux
`default_nettype wire

// ---- pin_mux_params.svh ----
// constants for the multifunction status pin selector
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// register offsets on the plain port
`define FUNC_OFS 8'h00
`define STAT_OFS 8'h04

// reset value of the pin function code
`define FUNC_RST 8'h00

// field positions of the pin function code
`define DIR_BIT 7
`define LOOP_HI 5
`define LOOP_LO 4

// high two bits that mark the loop status codes
`define LOOP_GRP 2'b11

// loop 0 only serves nibbles from here up
`define LOOP0_FIRST 4'ha

// status register bit positions
`define STAT_PIN 0
`define STAT_OE 1

`endif

// ---- pin_mux_pkg.sv ----
// types for the multifunction status pin selector
`default_nettype none
package pin_mux_pkg;

	// status flags of one digital loop
	typedef struct packed {
		logic phase_lock;
		logic freq_lock;
		logic analog_lock;
		logic analog_cal;
		logic free_run;
		logic holdover;
		logic switching;
		logic hist_avail;
		logic hist_upd;
		logic clamp;
		logic slew_limited;
		logic demap_clamped;
		logic sync_pulse;
	} loop_flags_t;

	// low nibble of a loop status code
	typedef enum logic [3:0] {
		SEL_PHASE = 4'h0,
		SEL_FREQ = 4'h1,
		SEL_ANALOG = 4'h2,
		SEL_CAL = 4'h3,
		SEL_ACTIVE = 4'h4,
		SEL_FREE = 4'h5,
		SEL_HOLD = 4'h6,
		SEL_SWITCH = 4'h7,
		SEL_HAVAIL = 4'h8,
		SEL_HUPD = 4'h9,
		SEL_CLAMP = 4'ha,
		SEL_SLEW = 4'hb,
		SEL_SYNC = 4'hc,
		SEL_DEMAP = 4'hd
	} flag_sel_e;

	// whole state of the selector
	typedef struct packed {
		logic [7:0] func_code;
		logic pin;
		logic pin_oe;
		logic [7:0] rdata;
	} mux_state_t;

endpackage : pin_mux_pkg
`default_nettype wire

// ---- status_pin_board.sv ----
// board model that samples the multifunction status pin
`default_nettype none
module status_pin_board (
	// pin as the device drives it
	input wire logic pin_in,
	input wire logic oe_in,
	// level the board logic sees
	output logic level_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// pull-down holds the net low while the device is not driving
	assign level_out = oe_in ? pin_in : 1'b0;
endmodule : status_pin_board
`default_nettype wire

// ---- test_multifunction_pin_status_mux.sv ----
// self-checking bench for the multifunction status pin selector
`include "pin_mux_params.svh"
`default_nettype none
module test_multifunction_pin_status_mux;
	timeunit 1ns;
	timeprecision 100ps;
	// flag bit of each low nibble, -2 for loop active, -1 unlisted
	localparam int POS [16] = '{12, 11, 10, 9, -2, 8, 7, 6, 5, 4, 3, 2, 0, 1, -1, -1};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	pin_mux_pkg::loop_flags_t [3:0] flags = '0;
	logic [3:0][3:0] acts = '0;
	logic pin;
	logic pin_oe;
	logic level;
	int error_cnt = 0;
	int compares = 0;

	// device and the board behind its pin
	pin_status_mux #(.LOOPS(4), .REFS(4)) DUT (
		.ref_clk_in(ref_clk), .rst_n_in(rst_n),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.flags_in(flags), .ref_active_in(acts),
		.pin_out(pin), .pin_oe_out(pin_oe)
	);
	status_pin_board board (.pin_in(pin), .oe_in(pin_oe), .level_out(level));

	// 200 mhz clock
	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic report_and_stop;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	// bus cycles, entered right after a rising edge
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 check(rdata, exp, what);
		@(posedge ref_clk);
	endtask : read_reg

	// one code: lone flag high, then every other source high and the flag low
	task automatic check_code(input logic [7:0] c);
		pin_mux_pkg::loop_flags_t [3:0] f;
		logic [3:0][3:0] a;
		logic [1:0] l;
		int p;
		l = c[5:4];
		p = (l == 2'd0 && c[3:0] < 4'ha) ? -1 : POS[c[3:0]];
		write_reg(`FUNC_OFS, c);
		f = '0;
		a = '0;
		if (p >= 0) f[l][p] = 1'b1;
		if (p == -2) a[l + 2'd1][l] = 1'b1;
		flags <= f;
		acts <= a;
		@(posedge ref_clk);
		#1 check({7'h00, level}, {7'h00, p != -1}, "selected source high");
		check({7'h00, pin_oe}, 8'h01, "output enable");
		f = '1;
		a = '1;
		if (p >= 0) f[l][p] = 1'b0;
		for (int r = 0; r < 4; r++) if (p == -2) a[r][l] = 1'b0;
		@(posedge ref_clk);
		flags <= f;
		acts <= a;
		@(posedge ref_clk);
		#1 check({7'h00, level}, 8'h00, "selected source low");
		@(posedge ref_clk);
	endtask : check_code

	// input codes and codes below the loop range keep the pin low
	task automatic check_quiet_codes;
		logic [7:0] codes [5] = '{8'h00, 8'h45, 8'h7f, 8'h80, 8'hbf};
		foreach (codes[i])
		begin
			write_reg(`FUNC_OFS, codes[i]);
			flags <= '1;
			acts <= '1;
			@(posedge ref_clk);
			#1 check({7'h00, pin}, 8'h00, "pin low");
			check({7'h00, pin_oe}, {7'h00, codes[i][7]}, "enable follows top bit");
			@(posedge ref_clk);
		end
	endtask : check_quiet_codes

	// register reset values, read back, read-only status, unmapped place
	task automatic check_regs;
		pin_mux_pkg::loop_flags_t [3:0] f;
		f = '0;
		f[1].phase_lock = 1'b1;
		read_reg(`FUNC_OFS, `FUNC_RST, "code after reset");
		read_reg(`STAT_OFS, 8'h00, "status after reset");
		write_reg(`FUNC_OFS, 8'hd0);
		flags <= f;
		@(posedge ref_clk);
		@(posedge ref_clk);
		read_reg(`FUNC_OFS, 8'hd0, "code read back");
		read_reg(`STAT_OFS, 8'h03, "status pin and enable");
		write_reg(`STAT_OFS, 8'h00);
		read_reg(`STAT_OFS, 8'h03, "status ignores writes");
		read_reg(8'h08, 8'h00, "unmapped read");
	endtask : check_regs

	// reset in mid-run drops the pin at once and clears the code
	task automatic check_reset;
		rst_n <= 1'b0;
		#1 check({6'h00, pin_oe, pin}, 8'h00, "pin released in reset");
		@(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		read_reg(`FUNC_OFS, `FUNC_RST, "code cleared by reset");
	endtask : check_reset

	// one-cycle history pulse shows for exactly one cycle
	task automatic check_pulse;
		write_reg(`FUNC_OFS, 8'hd9);
		flags <= '0;
		acts <= '0;
		@(posedge ref_clk);
		flags[1].hist_upd <= 1'b1;
		@(posedge ref_clk);
		flags[1].hist_upd <= 1'b0;
		#1 check({7'h00, level}, 8'h01, "pulse shown");
		@(posedge ref_clk);
		#1 check({7'h00, level}, 8'h00, "pulse gone");
		@(posedge ref_clk);
	endtask : check_pulse

	// main sequence after 8 cycles of reset
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		check_regs();
		check_reset();
		check_quiet_codes();
		for (int n = 0; n < 16; n++) check_code({4'hc, 4'(n)});
		for (int n = 0; n < 16; n++) check_code({4'hd, 4'(n)});
		for (int n = 0; n < 16; n++) check_code({4'he, 4'(n)});
		for (int n = 0; n < 16; n++) check_code({4'hf, 4'(n)});
		check_pulse();
		report_and_stop();
	end

	// hang guard
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		$display("mismatch at %0t: run limit reached", $time);
		report_and_stop();
	end
endmodule : test_multifunction_pin_status_mux
`default_nettype wire
